// ---- verilog/amb_ctrl.sv ----
/*
  amb_ctrl: host-side controller for a byte-wide asynchronous nonvolatile
  memory. it drives select, write strobe, output gate, address and data.
  assumes the memory pins are wired directly and that the data bus wire is
  resolved outside from DQ_O and DQ_OE_N.
*/
`timescale 1ns/100ps
// Function
// - write strobe stays high during reads
// - raised strobe/select stay high 2 ns
// - select falls at least 35 ns apart
// - write cycle at least 35 ns
// - address stable 18/20 ns through write
// - write pulse at least 15 ns
// - data setup 10 ns, hold 0
// - short recovery needs select raised each cycle
// - strobe high to select low 12 ns
// - pin modes: unselected, disabled, read, write
// - hold select, strobe high 2 ms startup
module amb_ctrl
  import amb_pkg::*;
#(
  parameter int START_CYCLES = CYC_START
)
(
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // user request side
  input wire logic REQ,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic READY,
  output logic DONE,
  output logic [DATA_W-1:0] RDATA,
  // memory pins
  output logic [ADDR_W-1:0] MEM_A,
  output logic MEM_SEL_N,
  output logic MEM_WR_N,
  output logic MEM_OE_N,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE_N
);
  amb_state_t state;
  amb_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [DATA_W-1:0] dq_sync;

  // read data crosses from the pins, so it passes the synchroniser
  amb_sync #(.W(DATA_W)) u_sync
  (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .d(DQ_I),
    .q(dq_sync)
  );

  wire cnt_zero = (cnt == '0);
  wire take = (state == AMB_IDLE) && REQ;

  // sequencing; each phase is held for its counted cycles
  always_comb
  begin
    next_state = state;
    next_cnt = cnt_zero ? cnt : cnt - 1'b1;
    case (state)
      AMB_BOOT:
        if (cnt_zero)
          next_state = AMB_IDLE;
      AMB_IDLE:
        if (REQ)
        begin
          next_state = REQ_WRITE ? AMB_WR : AMB_RD;
          // a write pulse lasts whole cycles; reads add synchroniser latency
          next_cnt = REQ_WRITE ? CNT_W'(CYC_WPULSE - 1) : CNT_W'(CYC_READ + 2);
        end
      AMB_RD, AMB_WR:
        if (cnt_zero)
        begin
          next_state = AMB_REC;
          next_cnt = CNT_W'(CYC_RECOVER + CYC_TURN + CYC_HIGH - 1);
        end
      AMB_REC:
        if (cnt_zero)
          next_state = AMB_IDLE;
      default:
        next_state = AMB_BOOT;
    endcase
  end

  // pin levels per state: select and strobe high outside access
  wire next_sel_n = !(next_state == AMB_RD || next_state == AMB_WR);
  wire next_wr_n = !(next_state == AMB_WR);
  wire next_oe_n = !(next_state == AMB_RD);
  wire next_dq_oe_n = !(next_state == AMB_WR); // drive only under a write
  wire rd_end = (state == AMB_RD) && cnt_zero;

  // state and counter
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state <= AMB_BOOT;
      cnt <= CNT_W'(START_CYCLES);
    end
    else if (CE)
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // pin registers; address and data stay put until the next request
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      MEM_A <= '0;
      DQ_O <= '0;
      MEM_SEL_N <= 1'b1;
      MEM_WR_N <= 1'b1;
      MEM_OE_N <= 1'b1;
      DQ_OE_N <= 1'b1;
    end
    else if (CE)
    begin
      if (take)
      begin
        MEM_A <= REQ_ADDR;
        DQ_O <= REQ_WDATA;
      end
      MEM_SEL_N <= next_sel_n;
      MEM_WR_N <= next_wr_n;
      MEM_OE_N <= next_oe_n;
      DQ_OE_N <= next_dq_oe_n;
    end
  end

  // user answers
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      READY <= 1'b0;
      DONE <= 1'b0;
      RDATA <= '0;
    end
    else if (CE)
    begin
      READY <= (next_state == AMB_IDLE);
      DONE <= (state == AMB_REC) && cnt_zero;
      if (rd_end)
        RDATA <= dq_sync;
    end
  end

  // data is never driven while the device may drive
  a_no_fight: assert property (@(posedge MCLK) disable iff (RST)
    !DQ_OE_N |-> MEM_OE_N)
    else $error("data driven with output gate low");
  a_read_strobe: assert property (@(posedge MCLK) disable iff (RST)
    !MEM_OE_N |-> MEM_WR_N)
    else $error("strobe low during read");
  a_write_sel: assert property (@(posedge MCLK) disable iff (RST)
    !MEM_WR_N |-> !MEM_SEL_N && !DQ_OE_N)
    else $error("write without select or data");
  a_boot_idle: assert property (@(posedge MCLK) disable iff (RST)
    state == AMB_BOOT |-> MEM_SEL_N && MEM_WR_N)
    else $error("pins active during startup");
  sequence s_sel_rise;
    $rose(MEM_SEL_N);
  endsequence
  a_sel_recover: assert property (@(posedge MCLK) disable iff (RST || !CE)
    s_sel_rise |-> MEM_SEL_N [*2])
    else $error("select recovery too short");
  a_addr_stable: assert property (@(posedge MCLK) disable iff (RST)
    !MEM_SEL_N && !$rose(!MEM_SEL_N) |-> $stable(MEM_A))
    else $error("address moved during access");
  a_read_len: assert property (@(posedge MCLK) disable iff (RST || !CE)
    $fell(MEM_OE_N) |-> !MEM_OE_N [*3])
    else $error("read access too short");
  a_wr_pulse: assert property (@(posedge MCLK) disable iff (RST)
    $fell(MEM_WR_N) |-> !MEM_SEL_N)
    else $error("write pulse without select");
  // a raised strobe stays up through the turnaround
  sequence s_wr_rise;
    $rose(MEM_WR_N);
  endsequence
  a_wr_recover: assert property (@(posedge MCLK) disable iff (RST || !CE)
    s_wr_rise |-> MEM_WR_N [*2])
    else $error("strobe recovery too short");
  // every write starts from a deselected chip, so select is raised each cycle
  a_sel_each: assert property (@(posedge MCLK) disable iff (RST)
    $fell(MEM_WR_N) |-> $past(MEM_SEL_N))
    else $error("write began without select raised");
  // a new address only after a full cycle has passed
  a_addr_cycle: assert property (@(posedge MCLK) disable iff (RST)
    $changed(MEM_A) |=> $stable(MEM_A))
    else $error("address changed twice in a row");
  // ready is only shown while every pin is parked
  a_ready_idle: assert property (@(posedge MCLK) disable iff (RST)
    READY |-> MEM_SEL_N && MEM_WR_N && MEM_OE_N && DQ_OE_N)
    else $error("ready while pins active");
  // the gate only opens on a selected chip
  a_gate_sel: assert property (@(posedge MCLK) disable iff (RST)
    !MEM_OE_N |-> !MEM_SEL_N)
    else $error("gate low while deselected");
  // one access ends in one pulse; a frozen clock enable stretches it legally
  a_done_pulse: assert property (@(posedge MCLK) disable iff (RST || !CE)
    DONE |=> !DONE)
    else $error("done longer than one cycle");
endmodule

// ---- common/amb_pkg.sv ----
/*
  amb_pkg: constants for the byte-wide asynchronous memory controller.
  assumes a 25 MHz MCLK; the access, pulse, recovery, turnaround and high times are turned into whole cycles here.
*/
package amb_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  // pin timings in ns
  localparam int T_CYCLE_NS = 35;
  localparam int T_GLQV_NS = 15;
  localparam int T_ELQV_NS = 35;
  localparam int T_WLWH_NS = 15;
  localparam int T_DVWH_NS = 10;
  localparam int T_HIGH_NS = 2;
  localparam int T_WHEL_NS = 12;
  localparam int T_GHQZ_NS = 10;
  // least times round up, never below one cycle
  localparam int CYC_READ = (T_ELQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CYC_WPULSE = (T_WLWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RECOVER = (T_WHEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_TURN = (T_GHQZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_HIGH = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // startup: 2 ms held idle after reset
  localparam int T_START_US = 2000;
  localparam int CYC_START = T_START_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 17;
  typedef enum logic [2:0] {AMB_BOOT, AMB_IDLE, AMB_RD, AMB_WR, AMB_REC} amb_state_t;
endpackage

// ---- verilog/amb_sync.sv ----
/*
  amb_sync: three-stage synchroniser with agreement on the last two stages.
  assumes the input comes from outside MCLK; stage one feeds stage two only.
*/
`timescale 1ns/100ps
module amb_sync
  import amb_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // value accepted once stages two and three agree
  wire [W-1:0] agree = ~(s2 ^ s3);
  wire [W-1:0] next_q = (agree & s3) | (~agree & q);

  // shift chain, frozen while ce is low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// ---- verification/amb_mem_model.sv ----
/* amb_mem_model: behavioural byte memory at the far side of amb_ctrl.
   assumes the bench resolves the data wire. */
`timescale 1ns/100ps
module amb_mem_model
  import amb_pkg::*;
(
  // memory pins
  input wire logic [ADDR_W-1:0] MEM_A,
  input wire logic MEM_SEL_N,
  input wire logic MEM_WR_N,
  input wire logic MEM_OE_N,
  // data wire, split
  input wire logic [DATA_W-1:0] DIN,
  output logic [DATA_W-1:0] DOUT,
  output logic DRIVE
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last = 8'h00;
  wire write_on = !MEM_SEL_N && !MEM_WR_N;
  wire read_on = !MEM_SEL_N && !MEM_OE_N && MEM_WR_N;
  wire read_late;
  wire [ADDR_W-1:0] a_late;
  wire [ADDR_W-1:0] a_rd;
  wire [DATA_W-1:0] d_late;
  // late copies, so pins moving with the closing edge are seen as before it
  assign #5 a_late = MEM_A;
  assign #5 d_late = DIN;
  assign #3 a_rd = MEM_A;
  // slow to start driving, quick to stop
  assign #10 read_late = read_on;
  assign DRIVE = read_on && read_late;
  // a released wire shows the inverse of the last byte, never stale data
  assign DOUT = DRIVE ? mem[a_rd] : ~last;
  always @(negedge write_on) mem[a_late] <= d_late;
  always @(DOUT or DRIVE) if (DRIVE) last = DOUT;
endmodule

// ---- verification/tb.sv ----
/* tb: self-checking bench for amb_ctrl with a behavioural memory.
   assumes a short startup count so the run stays brief. */
`timescale 1ns/100ps
module tb
  import amb_pkg::*;
;
  localparam int START = 20;
  logic MCLK = 0, RST = 1, CE = 1, REQ = 0, REQ_WRITE = 0;
  logic [ADDR_W-1:0] REQ_ADDR = '0, MEM_A;
  logic [DATA_W-1:0] REQ_WDATA = '0, RDATA, DQ_O, mdout, dq;
  logic READY, DONE, MEM_SEL_N, MEM_WR_N, MEM_OE_N, DQ_OE_N, mdrive;
  int fails = 0, checks_done = 0;
  // resolved data wire: host drive wins
  assign dq = DQ_OE_N ? mdout : DQ_O;
  amb_ctrl #(.START_CYCLES(START)) amb_ctrl_inst (.MCLK(MCLK), .RST(RST), .CE(CE),
    .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .READY(READY), .DONE(DONE), .RDATA(RDATA), .MEM_A(MEM_A), .MEM_SEL_N(MEM_SEL_N),
    .MEM_WR_N(MEM_WR_N), .MEM_OE_N(MEM_OE_N), .DQ_I(dq), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N));
  amb_mem_model amb_mem_model_inst (.MEM_A(MEM_A), .MEM_SEL_N(MEM_SEL_N),
    .MEM_WR_N(MEM_WR_N), .MEM_OE_N(MEM_OE_N), .DIN(dq), .DOUT(mdout), .DRIVE(mdrive));
  initial forever #20 MCLK = ~MCLK;
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic final_report;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // pin watch every cycle
  always @(negedge MCLK)
  begin
    if (!MEM_SEL_N && !MEM_OE_N) chk(MEM_WR_N, "strobe low in read");
    if (!DQ_OE_N) chk(!mdrive, "two drivers");
  end
  // one access; enable held low for stall cycles once taken
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input int stall);
    int n;
    for (n = 0; n < 300 && READY !== 1'b1; n++) @(negedge MCLK);
    chk(n < 300, "ready timeout");
    if (n == 300) final_report();
    {REQ, REQ_WRITE, REQ_ADDR, REQ_WDATA} = {1'b1, wr, a, d};
    @(negedge MCLK);
    REQ = 0;
    CE = (stall == 0);
    repeat (stall) @(negedge MCLK);
    chk(DONE === 1'b0, "done while frozen");
    CE = 1;
    for (n = 0; n < 50 && DONE !== 1'b1; n++) @(negedge MCLK);
    chk(n < 50, "done timeout");
    if (n == 50) final_report();
  endtask
  // pins idle high, ready held low during startup
  task automatic t_startup;
    repeat (START - 2)
    begin
      @(negedge MCLK);
      chk(READY === 1'b0 && MEM_SEL_N === 1'b1 && MEM_WR_N === 1'b1, "startup");
    end
  endtask
  // boundary addresses written back to back, then read back
  task automatic t_rw(input int stall);
    logic [ADDR_W-1:0] a[3] = '{17'h0_0000, 17'h1_FFFF, 17'h0_AAAA};
    logic [DATA_W-1:0] d[3] = '{8'hA5, 8'h5A, 8'hFF};
    foreach (a[i]) access(1'b1, a[i], d[i] ^ 8'(stall), 0);
    foreach (a[i])
    begin
      chk(amb_mem_model_inst.mem[a[i]] === (d[i] ^ 8'(stall)), "stored");
      access(1'b0, a[i], 8'h00, stall);
      chk(RDATA === (d[i] ^ 8'(stall)), "read");
    end
  endtask
  // reset in mid-write parks the pins
  task automatic t_reset;
    int n;
    for (n = 0; n < 300 && READY !== 1'b1; n++) @(negedge MCLK);
    chk(n < 300, "ready timeout before reset");
    if (n == 300) final_report();
    {REQ, REQ_WRITE} = 2'b11;
    @(negedge MCLK);
    {REQ, RST} = 2'b01;
    @(negedge MCLK);
    RST = 0;
    chk({MEM_SEL_N, MEM_WR_N, MEM_OE_N, DQ_OE_N, READY} === 5'b11110, "reset");
  endtask
  initial
  begin
    repeat (3) @(negedge MCLK);
    RST = 0;
    t_startup();
    t_rw(0);
    t_rw(12);
    t_reset();
    t_startup();
    t_rw(3);
    final_report();
  end
endmodule
